// ===== tb/gpsp_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bus controller model
module gpsp_ctl (
	input wire logic clk_i, // clock
	input wire logic [7:0] dio_i, // wired dio
	output var logic atn_n_o, // attention
	output var logic eoi_n_o, // end
	output var logic dav_n_o, // data valid
	output var logic ren_n_o, // remote
	output var logic [7:0] dio_n_o // data
);
	initial
	begin
		{atn_n_o, eoi_n_o, dav_n_o, ren_n_o} = 4'hF;
		dio_n_o = 8'hFF;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// attention and the byte together, then data valid
	task automatic cmd(input logic [7:0] c);
		atn_n_o = 1'h0;
		dio_n_o = ~c;
		gap(3);
		dav_n_o = 1'h0;
		gap(4);
		dav_n_o = 1'h1;
		gap(3);
		dio_n_o = 8'hFF; // released, pulled up
	endtask
	task automatic go;
		atn_n_o = 1'h1;
		gap(6);
	endtask
	// remote enable level, high asserts the pin
	task automatic remote(input logic on);
		ren_n_o = ~on;
	endtask
	// untalk, address, release
	task automatic talk(input logic [7:0] a);
		cmd(8'h5F);
		cmd(a);
		go();
	endtask
	// listen, configure, enable or disable
	task automatic conf(input logic [7:0] b);
		cmd(8'h25);
		cmd({1'h0, gpsp_pkg::CMD_PPC});
		cmd(b);
		cmd(8'h3F);
		go();
	endtask
	// attention with end
	task automatic pp(output logic [7:0] r);
		{atn_n_o, eoi_n_o} = 2'h0;
		gap(6);
		r = ~dio_i;
		{atn_n_o, eoi_n_o} = 2'h3;
		gap(6);
	endtask
endmodule
`default_nettype wire

// ===== tb/gpsp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks
module gpsp_top_sva (
	input wire logic mclk_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic bus_atn_n_i, // attention
	input wire logic bus_ren_n_i, // remote
	input wire logic svc_req_i, // service
	input wire logic stat_sent_i, // byte taken
	input wire logic [7:0] user_stat_i, // status
	input wire logic [7:0] dev_data_i, // data
	input wire logic srq_oe_o, // srq drive
	input wire logic [7:0] dio_oe_o, // dio drive
	input wire logic talker_o, // talker
	input wire logic talk_en_o, // talking
	input wire logic [7:0] talk_byte_o, // byte out
	input wire logic spoll_o, // poll mode
	input wire logic pp_cfg_o, // pp set
	input wire logic lockout_o, // lockout
	input wire logic dev_clear_o // clear
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	chk_srq_set: assert property (svc_req_i |=> srq_oe_o) else $error("srq not raised");
	chk_srq_hold: assert property (srq_oe_o && !stat_sent_i |=> srq_oe_o || dev_clear_o || $past(dev_clear_o))
		else $error("srq dropped early");
	chk_srq_clear: assert property (stat_sent_i && talk_en_o && spoll_o && !svc_req_i |=> !srq_oe_o)
		else $error("srq kept");
	chk_stat_byte: assert property (spoll_o && $past(spoll_o) && $stable(srq_oe_o) && $stable(user_stat_i)
		|-> talk_byte_o == {user_stat_i[7], srq_oe_o, user_stat_i[5:0]}) else $error("bad status");
	chk_data_byte: assert property (!spoll_o && !$past(spoll_o) && !$past(sys_rst_i) && !$past(sys_rst_i, 2)
		&& $stable(dev_data_i) |-> talk_byte_o == dev_data_i) else $error("bad data");
	chk_pp_quiet: assert property (bus_atn_n_i [*5] |-> dio_oe_o == 8'h00) else $error("dio outside poll");
	chk_pp_unconf: assert property (!pp_cfg_o && !$past(pp_cfg_o) |-> dio_oe_o == 8'h00)
		else $error("dio unconfigured");
	chk_pp_one: assert property ($onehot0(dio_oe_o)) else $error("many lines");
	chk_clear_pulse: assert property (dev_clear_o |=> !dev_clear_o) else $error("clear long");
	chk_talk_en: assert property (talk_en_o |-> talker_o || $past(talker_o)) else $error("not talker");
	chk_ren_local: assert property (bus_ren_n_i [*5] |-> !lockout_o) else $error("lockout kept");
	cover property (srq_oe_o ##1 !srq_oe_o);
	cover property (|dio_oe_o);
	cover property (spoll_o && talk_en_o);
endmodule
bind gpsp_top gpsp_top_sva chk (.mclk_i, .sys_rst_i, .bus_atn_n_i, .bus_ren_n_i, .svc_req_i, .stat_sent_i,
	.user_stat_i, .dev_data_i, .srq_oe_o, .dio_oe_o, .talker_o, .talk_en_o, .talk_byte_o, .spoll_o,
	.pp_cfg_o, .lockout_o, .dev_clear_o);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module tb;
	logic mclk_i, sys_rst_i, svc_req_i, stat_sent_i, ext_en_i, clr_seen = 1'h0;
	logic [4:0] my_addr_i, my_sec_i;
	logic [7:0] user_stat_i, dev_data_i, r, dio_c, bus_dio_n_i, dio_n_o, dio_oe_o, talk_byte_o;
	logic bus_atn_n_i, bus_eoi_n_i, bus_dav_n_i, bus_ren_n_i, srq_n_o, srq_oe_o, talker_o, listener_o;
	logic talk_en_o, spoll_o, pp_cfg_o, lockout_o, dev_clear_o;
	int errors = 0, checks_done = 0;
	typedef struct {logic [7:0] c; logic s, t, l;} gpsp_row_type;
	gpsp_row_type rows [7] = '{'{8'h11, 1'h0, 1'h0, 1'h1}, '{8'h18, 1'h1, 1'h0, 1'h1}, '{8'h45, 1'h1, 1'h1, 1'h1},
		'{8'h46, 1'h1, 1'h0, 1'h1}, '{8'h45, 1'h1, 1'h1, 1'h1}, '{8'h5F, 1'h1, 1'h0, 1'h1}, '{8'h19, 1'h0, 1'h0, 1'h1}};
	gpsp_top uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_atn_n_i(bus_atn_n_i), .bus_eoi_n_i(bus_eoi_n_i),
		.bus_dav_n_i(bus_dav_n_i), .bus_ren_n_i(bus_ren_n_i), .bus_dio_n_i(bus_dio_n_i), .my_addr_i(my_addr_i),
		.my_sec_i(my_sec_i), .ext_en_i(ext_en_i), .svc_req_i(svc_req_i), .user_stat_i(user_stat_i),
		.dev_data_i(dev_data_i), .stat_sent_i(stat_sent_i), .srq_n_o(srq_n_o), .srq_oe_o(srq_oe_o),
		.dio_n_o(dio_n_o), .dio_oe_o(dio_oe_o), .talker_o(talker_o), .listener_o(listener_o),
		.talk_en_o(talk_en_o), .talk_byte_o(talk_byte_o), .spoll_o(spoll_o), .pp_cfg_o(pp_cfg_o),
		.lockout_o(lockout_o), .dev_clear_o(dev_clear_o));
	gpsp_ctl ctl (.clk_i(mclk_i), .dio_i(bus_dio_n_i), .atn_n_o(bus_atn_n_i), .eoi_n_o(bus_eoi_n_i),
		.dav_n_o(bus_dav_n_i), .ren_n_o(bus_ren_n_i), .dio_n_o(dio_c));
	assign bus_dio_n_i = dio_c & (dio_n_o | ~dio_oe_o);
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (dev_clear_o === 1'h1) clr_seen <= 1'h1;
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		ctl.gap(1);
		s = 1'h0;
		ctl.gap(1);
	endtask
	task automatic serial;
		ctl.cmd({1'h0, gpsp_pkg::CMD_SPE});
		ctl.talk(8'h45);
		`CHK(talk_en_o, 1'h1)
		`CHK(talk_byte_o, 8'hC1)
		pulse(stat_sent_i);
		`CHK(srq_oe_o, 1'h0)
		`CHK(talk_byte_o, 8'h81)
		ctl.cmd({1'h0, gpsp_pkg::CMD_SPD});
		ctl.go();
		`CHK(talk_byte_o, 8'h3C)
	endtask
	initial
	begin
		#100000;
		errors++;
		end_of_test();
	end
	initial
	begin
		mclk_i = 1'h0;
		sys_rst_i = 1'h1;
		svc_req_i = 1'h0;
		stat_sent_i = 1'h0;
		ext_en_i = 1'h0;
		my_addr_i = 5'h05;
		my_sec_i = 5'h09;
		user_stat_i = 8'h81;
		dev_data_i = 8'h3C;
		ctl.gap(2);
		`CHK({srq_oe_o, dio_oe_o, talker_o, spoll_o, lockout_o}, 12'h000)
		sys_rst_i = 1'h0;
		ctl.remote(1'h1);
		ctl.gap(4);
		foreach (rows[i])
		begin
			ctl.cmd(rows[i].c);
			`CHK(spoll_o, rows[i].s)
			`CHK(talker_o, rows[i].t)
			`CHK(lockout_o, rows[i].l)
		end
		ctl.go();
		$display("test commands done");
		pulse(svc_req_i);
		`CHK(srq_oe_o, 1'h1)
		`CHK({srq_n_o, dio_n_o}, 9'h000)
		pulse(stat_sent_i);
		`CHK(srq_oe_o, 1'h1)
		serial();
		$display("test serial poll done");
		ctl.conf(8'h6B);
		`CHK(pp_cfg_o, 1'h1)
		ctl.pp(r);
		`CHK(r, 8'h00)
		pulse(svc_req_i);
		ctl.pp(r);
		`CHK(r, 8'h08)
		serial();
		ctl.pp(r);
		`CHK(r, 8'h00)
		ctl.conf(8'h67);
		ctl.pp(r);
		`CHK(r, 8'h80)
		ctl.cmd({1'h0, gpsp_pkg::CMD_PPU});
		ctl.go();
		`CHK(pp_cfg_o, 1'h0)
		ctl.pp(r);
		`CHK(r, 8'h00)
		ctl.conf(8'h60);
		ctl.conf(8'h70);
		`CHK(pp_cfg_o, 1'h0)
		$display("test parallel poll done");
		pulse(svc_req_i);
		ctl.cmd({1'h0, gpsp_pkg::CMD_DCL});
		ctl.go();
		`CHK(clr_seen, 1'h1)
		`CHK(srq_oe_o, 1'h0)
		ext_en_i = 1'h1;
		ctl.cmd(8'h45);
		ctl.cmd(8'h6A);
		`CHK(talker_o, 1'h0)
		ctl.cmd(8'h45);
		ctl.cmd(8'h69);
		`CHK(talker_o, 1'h1)
		ctl.go();
		$display("test clear and extended done");
		ext_en_i = 1'h0;
		my_addr_i = 5'h1E;
		my_sec_i = 5'h1F;
		user_stat_i = 8'h5A;
		dev_data_i = 8'hA5;
		ctl.cmd(8'h45);
		`CHK(talker_o, 1'h0)
		ctl.cmd(8'h3E);
		`CHK(listener_o, 1'h1)
		ctl.cmd(8'h3F);
		`CHK(listener_o, 1'h0)
		ctl.cmd({1'h0, gpsp_pkg::CMD_SPE});
		ctl.talk(8'h5E);
		`CHK(talk_byte_o, 8'h1A)
		ctl.cmd({1'h0, gpsp_pkg::CMD_SPD});
		ctl.go();
		`CHK(talk_byte_o, 8'hA5)
		ext_en_i = 1'h1;
		ctl.cmd(8'h5E);
		ctl.cmd(8'h7F);
		`CHK(talker_o, 1'h1)
		ctl.go();
		sys_rst_i = 1'h1;
		ctl.gap(2);
		`CHK({talker_o, listener_o, spoll_o, lockout_o, srq_oe_o, pp_cfg_o}, 6'h00)
		sys_rst_i = 1'h0;
		ctl.gap(4);
		ctl.cmd({1'h0, gpsp_pkg::CMD_LLO});
		`CHK(lockout_o, 1'h1)
		ctl.go();
		ctl.remote(1'h0);
		ctl.gap(6);
		`CHK(lockout_o, 1'h0)
		$display("test address and reset done");
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== verilog/gpsp_cmd_dec.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// interface command byte decode
module gpsp_cmd_dec (
	input wire logic [6:0] cmd_i, // command byte, ATN asserted
	output logic is_dcl_o, // device clear
	output logic is_llo_o, // local lockout
	output logic is_spe_o, // serial poll enable
	output logic is_spd_o, // serial poll disable
	output logic is_ppu_o, // parallel poll unconfigure
	output logic is_ppc_o, // parallel poll configure
	output logic is_tag_o, // talk address, not untalk
	output logic is_unt_o, // untalk
	output logic is_lag_o, // listen address, not unlisten
	output logic is_unl_o, // unlisten
	output logic is_scg_o, // secondary group
	output logic is_ppe_o, // secondary as enable
	output logic is_ppd_o, // secondary as disable
	output logic [4:0] addr_o // address field
);
	wire logic [1:0] grp = cmd_i[6:gpsp_pkg::GRP_LSB];
	wire logic all_addr = (cmd_i[4:0] == gpsp_pkg::ADDR_ALL);

	assign addr_o = cmd_i[4:0];
	assign is_dcl_o = (cmd_i == gpsp_pkg::CMD_DCL);
	assign is_llo_o = (cmd_i == gpsp_pkg::CMD_LLO);
	assign is_spe_o = (cmd_i == gpsp_pkg::CMD_SPE);
	assign is_spd_o = (cmd_i == gpsp_pkg::CMD_SPD);
	assign is_ppu_o = (cmd_i == gpsp_pkg::CMD_PPU);
	assign is_ppc_o = (cmd_i == gpsp_pkg::CMD_PPC);
	assign is_tag_o = (grp == gpsp_pkg::GRP_TAG) && !all_addr;
	assign is_unt_o = (grp == gpsp_pkg::GRP_TAG) && all_addr;
	assign is_lag_o = (grp == gpsp_pkg::GRP_LAG) && !all_addr;
	assign is_unl_o = (grp == gpsp_pkg::GRP_LAG) && all_addr;
	assign is_scg_o = (grp == gpsp_pkg::GRP_SCG);
	assign is_ppe_o = is_scg_o && !cmd_i[gpsp_pkg::PPD_BIT];
	assign is_ppd_o = is_scg_o && cmd_i[gpsp_pkg::PPD_BIT];
endmodule
`default_nettype wire

// ===== verilog/gpsp_pkg.sv
`default_nettype none
// ==========================================
// bus command codes and field layout
package gpsp_pkg;
	// universal commands, seven-bit codes with ATN asserted
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_PPU = 7'h15;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	// addressed command valid only for addressed listeners
	localparam logic [6:0] CMD_PPC = 7'h05;
	// command group in bits 6:5
	localparam logic [1:0] GRP_LAG = 2'h1;
	localparam logic [1:0] GRP_TAG = 2'h2;
	localparam logic [1:0] GRP_SCG = 2'h3;
	// address value that unaddresses every device
	localparam logic [4:0] ADDR_ALL = 5'h1F;
	// field positions
	localparam int GRP_LSB = 5;
	localparam int PPD_BIT = 4;
	localparam int PP_SENSE_BIT = 3;
	localparam int STB_RSV_BIT = 6;
	// reset values
	localparam logic [7:0] DIO_RST = 8'h00;
	localparam logic [2:0] PP_LINE_RST = 3'h0;
	typedef enum logic [1:0] {
		TLK_IDLE,
		TLK_PRIM,
		TLK_ADDR
	} gpsp_tstate_type;
endpackage
`default_nettype wire

// ===== verilog/gpsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// two-stage synchroniser, one chain per bit
module gpsp_sync #(
	parameter int W = 12
) (
	input wire logic mclk_i, // system clock
	input wire logic sys_rst_i, // async reset, high
	input wire logic [W-1:0] d_i, // asynchronous levels
	output logic [W-1:0] q_o // synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta;
			logic sync_q;
			always_ff @(posedge mclk_i or posedge sys_rst_i)
			begin
				if (sys_rst_i)
				begin
					meta <= 1'b0;
					sync_q <= 1'b0;
				end
				else
				begin
					meta <= d_i[i];
					sync_q <= meta;
				end
			end
			assign q_o[i] = sync_q;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== verilog/gpsp_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpsp_top (
	input wire logic mclk_i, // 100 MHz system clock
	input wire logic sys_rst_i, // async reset, high
	input wire logic bus_atn_n_i, // ATN pin, low asserted
	input wire logic bus_eoi_n_i, // EOI pin, low asserted
	input wire logic bus_dav_n_i, // DAV pin, low asserted
	input wire logic bus_ren_n_i, // REN pin, low asserted
	input wire logic [7:0] bus_dio_n_i, // DIO pins, low asserted
	input wire logic [4:0] my_addr_i, // own primary address
	input wire logic [4:0] my_sec_i, // own secondary address
	input wire logic ext_en_i, // extended talker enable
	input wire logic svc_req_i, // service request pulse
	input wire logic [7:0] user_stat_i, // user status bits
	input wire logic [7:0] dev_data_i, // normal talker data
	input wire logic stat_sent_i, // talker byte taken pulse
	output logic srq_n_o, // SRQ drive level
	output logic srq_oe_o, // SRQ enable, high drives
	output logic [7:0] dio_n_o, // DIO drive levels
	output logic [7:0] dio_oe_o, // DIO enables, high drives
	output logic talker_o, // addressed to talk
	output logic listener_o, // addressed to listen
	output logic talk_en_o, // talker and ATN released
	output logic [7:0] talk_byte_o, // byte to send when talking
	output logic spoll_o, // serial poll mode
	output logic pp_cfg_o, // parallel poll configured
	output logic lockout_o, // local control locked out
	output logic dev_clear_o // device clear pulse
);
	// ==========================================
	// pin synchronisation
	wire logic [11:0] pin_raw = {~bus_ren_n_i, ~bus_dav_n_i, ~bus_eoi_n_i, ~bus_atn_n_i, ~bus_dio_n_i};
	logic [11:0] pin_s;

	gpsp_sync #(
		.W(12)
	) u_sync (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	wire logic [7:0] dio = pin_s[7:0];
	wire logic atn = pin_s[8];
	wire logic eoi = pin_s[9];
	wire logic dav = pin_s[10];
	wire logic ren = pin_s[11];

	// ==========================================
	// command byte capture
	logic dav_d;
	wire logic cmd_stb = atn && dav && !dav_d;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			dav_d <= 1'b0;
		else
			dav_d <= dav;
	end

	logic is_dcl;
	logic is_llo;
	logic is_spe;
	logic is_spd;
	logic is_ppu;
	logic is_ppc;
	logic is_tag;
	logic is_unt;
	logic is_lag;
	logic is_unl;
	logic is_scg;
	logic is_ppe;
	logic is_ppd;
	logic [4:0] cmd_addr;

	gpsp_cmd_dec u_dec (
		.cmd_i(dio[6:0]),
		.is_dcl_o(is_dcl),
		.is_llo_o(is_llo),
		.is_spe_o(is_spe),
		.is_spd_o(is_spd),
		.is_ppu_o(is_ppu),
		.is_ppc_o(is_ppc),
		.is_tag_o(is_tag),
		.is_unt_o(is_unt),
		.is_lag_o(is_lag),
		.is_unl_o(is_unl),
		.is_scg_o(is_scg),
		.is_ppe_o(is_ppe),
		.is_ppd_o(is_ppd),
		.addr_o(cmd_addr)
	);

	// ==========================================
	// talker addressing
	gpsp_pkg::gpsp_tstate_type tstate;
	gpsp_pkg::gpsp_tstate_type next_tstate;
	logic ppc_armed;
	wire logic my_addr_hit = (cmd_addr == my_addr_i);
	wire logic my_sec_hit = (cmd_addr == my_sec_i);
	wire logic talk_sec = is_scg && !ppc_armed;

	always_comb
	begin
		next_tstate = tstate;
		if (cmd_stb)
		begin
			if (is_unt)
				next_tstate = gpsp_pkg::TLK_IDLE;
			else if (is_tag && my_addr_hit)
				next_tstate = ext_en_i ? gpsp_pkg::TLK_PRIM : gpsp_pkg::TLK_ADDR;
			else if (is_tag)
				next_tstate = gpsp_pkg::TLK_IDLE;
			else if (talk_sec)
			begin
				unique case (tstate)
					gpsp_pkg::TLK_PRIM:
						next_tstate = my_sec_hit ? gpsp_pkg::TLK_ADDR : gpsp_pkg::TLK_IDLE;
					gpsp_pkg::TLK_IDLE,
					gpsp_pkg::TLK_ADDR:
						next_tstate = tstate;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tstate <= gpsp_pkg::TLK_IDLE;
		else
			tstate <= next_tstate;
	end

	wire logic next_talker = (next_tstate == gpsp_pkg::TLK_ADDR);

	// ==========================================
	// listener flag, needed for configure context
	logic next_listener;

	always_comb
	begin
		next_listener = listener_o;
		if (cmd_stb && is_lag && my_addr_hit)
			next_listener = 1'b1;
		else if (cmd_stb && is_unl)
			next_listener = 1'b0;
	end

	// ==========================================
	// universal commands and poll configuration
	wire logic pp_enable_cmd = cmd_stb && ppc_armed && is_ppe;
	wire logic pp_disable_cmd = cmd_stb && ((ppc_armed && is_ppd) || is_ppu);
	logic pp_en;
	logic [2:0] pp_line;
	logic pp_sense;
	logic spoll;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ppc_armed <= 1'b0;
		else if (cmd_stb)
			ppc_armed <= is_ppc && listener_o; // next byte only
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pp_en <= 1'b0;
			pp_line <= gpsp_pkg::PP_LINE_RST;
			pp_sense <= 1'b0;
		end
		else if (pp_enable_cmd)
		begin
			pp_en <= 1'b1;
			pp_line <= dio[2:0];
			pp_sense <= dio[gpsp_pkg::PP_SENSE_BIT];
		end
		else if (pp_disable_cmd)
			pp_en <= 1'b0;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			spoll <= 1'b0;
		else if (cmd_stb && is_spe)
			spoll <= 1'b1;
		else if (cmd_stb && is_spd)
			spoll <= 1'b0;
	end

	// ==========================================
	// service request and poll bit
	logic srq_pend;
	wire logic polled = stat_sent_i && talk_en_o && spoll_o;
	wire logic dcl_hit = cmd_stb && is_dcl;
	wire logic next_srq = svc_req_i || (srq_pend && !polled && !dcl_hit); // set wins

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			srq_pend <= 1'b0;
		else
			srq_pend <= next_srq;
	end

	// status byte, service bit on DIO-7
	logic [7:0] stat_byte;

	always_comb
	begin
		stat_byte = user_stat_i;
		stat_byte[gpsp_pkg::STB_RSV_BIT] = srq_pend;
	end

	// ==========================================
	// parallel poll response
	wire logic pp_poll = atn && eoi && pp_en;
	wire logic pp_assert = (srq_pend == pp_sense);
	logic [7:0] pp_drive;

	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_ppline
			assign pp_drive[i] = pp_poll && pp_assert && (pp_line == 3'(i));
		end
	endgenerate

	// ==========================================
	// registered outputs
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			srq_n_o <= 1'b0;
			srq_oe_o <= 1'b0;
			dio_n_o <= gpsp_pkg::DIO_RST;
			dio_oe_o <= gpsp_pkg::DIO_RST;
		end
		else
		begin
			srq_n_o <= 1'b0;
			srq_oe_o <= next_srq;
			dio_n_o <= gpsp_pkg::DIO_RST;
			dio_oe_o <= pp_drive;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			talker_o <= 1'b0;
			listener_o <= 1'b0;
			talk_en_o <= 1'b0;
			spoll_o <= 1'b0;
			pp_cfg_o <= 1'b0;
		end
		else
		begin
			talker_o <= next_talker;
			listener_o <= next_listener;
			talk_en_o <= next_talker && !atn;
			spoll_o <= spoll;
			pp_cfg_o <= pp_en;
		end
	end

	// status byte in poll mode, else device data
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			talk_byte_o <= gpsp_pkg::DIO_RST;
		else
			talk_byte_o <= spoll ? stat_byte : dev_data_i;
	end

	// lockout ends when remote enable drops
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			lockout_o <= 1'b0;
		else if (!ren)
			lockout_o <= 1'b0;
		else if (cmd_stb && is_llo)
			lockout_o <= 1'b1;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			dev_clear_o <= 1'b0;
		else
			dev_clear_o <= dcl_hit;
	end
endmodule
`default_nettype wire
